// File: lsm_pkg.sv
// Shared constants and types for the line status monitor register bank
package lsm_pkg;

   // -----------------------------------------------------------------
   // Channel layout and register indices (byte address = 4 * index)
   // -----------------------------------------------------------------
   localparam int         NUM_CH               = 4;
   localparam logic [7:0] LINE_STATUS_ZERO_IDX = 8'h14;
   localparam logic [7:0] LINE_STATUS_ONE_IDX  = 8'h15;
   localparam logic [7:0] FLAG_IDX             = 8'h16;
   localparam logic [7:0] MASK_IDX             = 8'h11;
   localparam logic [7:0] EDGE_IDX             = 8'h12;

   // -----------------------------------------------------------------
   // Field positions inside the status bytes
   // -----------------------------------------------------------------
   localparam int DF_POS  = 2;
   localparam int AIS_POS = 1;
   localparam int LOS_POS = 0;
   localparam int RLP_POS = 5;
   localparam int ATT_W   = 5;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [2:0]  MASK_RST  = 3'h7;
   localparam logic [2:0]  EDGE_RST  = 3'h0;
   localparam logic [2:0]  FLAG_RST  = 3'h0;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // -----------------------------------------------------------------
   // AHB-Lite encodings
   // -----------------------------------------------------------------
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic       HRESP_OKAY = 1'b0;

   // Bus slave states, Gray coded along idle, data, response
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_DATA = 2'b01,
      BUS_RESP = 2'b11
   } bus_state_t;

endpackage : lsm_pkg

// File: lsm_sync.sv
// Three-stage input synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
module lsm_sync #(
   parameter int W = 36
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] ff1_reg;
   logic [W-1:0] ff2_reg;
   logic [W-1:0] ff3_reg;

   // Shift chain; the first stage feeds only the second
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ff1_reg <= '0;
         ff2_reg <= '0;
         ff3_reg <= '0;
      end else begin
         ff1_reg <= d_in;
         ff2_reg <= ff1_reg;
         ff3_reg <= ff2_reg;
      end
   end

   // Per-bit acceptance; a bit moves only when stages two and three agree
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         q_out <= '0;
      end else begin
         q_out <= (ff3_reg & ~(ff2_reg ^ ff3_reg)) |
                  (q_out & (ff2_reg ^ ff3_reg));
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   AST_SYNC_AGREE: assert property (
      ((q_out ^ $past(q_out)) & $past(ff2_reg ^ ff3_reg)) == '0)
      else $error("Synchronised bit moved while stages disagreed");

endmodule : lsm_sync

// File: lsm_edge.sv
// Transition detector turning status changes into one-cycle events
`timescale 1ns/1ps
module lsm_edge #(
   parameter int W = 12
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] status_in,
   input  wire logic [W-1:0] edge_sel_in,
   output logic      [W-1:0] evt_out
);

   logic [W-1:0] prev_reg;

   // Previous-cycle copy, so each change is seen exactly once
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= status_in;
      end
   end

   // Rise always counts; fall counts only where any-change is selected
   assign evt_out = (status_in & ~prev_reg) |
                    (~status_in & prev_reg & edge_sel_in);

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   AST_EDGE_RISE: assert property (
      ((status_in & ~$past(status_in)) & ~evt_out) == '0)
      else $error("Rising status produced no event");

   AST_EDGE_FALL: assert property (
      (evt_out & ~status_in & ~edge_sel_in) == '0)
      else $error("Falling event without any-change select");

   AST_EDGE_ONCE: assert property (
      (evt_out & ~(status_in ^ $past(status_in))) == '0)
      else $error("Event raised without a status change");

endmodule : lsm_edge

// File: lsm_regs.sv
// Four-channel line status monitor registers behind an AHB-Lite slave
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module lsm_regs
   import lsm_pkg::*;
(
   input  wire logic        CLK_IN,
   input  wire logic        SYS_RST_IN,
   input  wire logic        HSEL_IN,
   input  wire logic [31:0] HADDR_IN,
   input  wire logic [1:0]  HTRANS_IN,
   input  wire logic        HWRITE_IN,
   input  wire logic [2:0]  HSIZE_IN,
   input  wire logic [31:0] HWDATA_IN,
   input  wire logic        HREADY_IN,
   input  wire logic [3:0]  DRV_FAULT_IN,
   input  wire logic [3:0]  ALARM_SIG_IN,
   input  wire logic [3:0]  SIG_LOSS_IN,
   input  wire logic [3:0]  REM_LOOP_IN,
   input  wire logic [19:0] LINE_ATTEN_IN,
   output logic      [31:0] HRDATA_OUT,
   output logic             HREADYOUT_OUT,
   output logic             HRESP_OUT,
   output logic             IRQ_OUT
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [35:0]      raw_in;
   logic [35:0]      sync_q;
   logic [3:0]       signal_loss_status;
   logic [3:0]       alarm_signal_status;
   logic [3:0]       driver_fault_status;
   logic [3:0]       remote_loopback_state;
   logic [3:0][4:0]  line_attenuation_code;
   logic [3:0][2:0]  stat_now;
   logic [3:0][2:0]  evt;
   logic [3:0][2:0]  new_evt;
   logic [3:0][2:0]  mask_reg;
   logic [3:0][2:0]  edge_sel_reg;
   logic [3:0][2:0]  flag_reg;
   logic [3:0][2:0]  flag_clr;
   bus_state_t       state_reg;
   bus_state_t       state_next;
   logic [7:0]       adr_reg;
   logic             wr_reg;
   logic             valid_reg;
   logic             capture;
   logic             acc_ok;
   logic             dp;
   logic [1:0]       cur_ch;
   logic [7:0]       rdata_next;
   logic             rd_flag;
   logic             wr_flag;
   logic             wr_stat;
   logic             rd_status_zero;
   logic             rd_status_one;

   // Register offset match within one channel's window
   function automatic logic hit(input logic [7:0] adr,
                                input logic [7:0] idx);
      return adr[5:0] == idx[5:0];
   endfunction : hit

   // ----------------------------------------------------------------
   // Line condition inputs
   // ----------------------------------------------------------------

   // Condition pins arrive from analogue detectors, off this clock
   assign raw_in = {LINE_ATTEN_IN, REM_LOOP_IN, DRV_FAULT_IN,
                    ALARM_SIG_IN, SIG_LOSS_IN};

   lsm_sync #(
      .W      (36)
   ) u_sync (
      .clk_in (CLK_IN),
      .rst_in (SYS_RST_IN),
      .d_in   (raw_in),
      .q_out  (sync_q)
   );

   // Attenuation bits settle independently; a code in motion may
   // read for a cycle as any mix of its old and new bits
   assign signal_loss_status    = sync_q[3:0];
   assign alarm_signal_status   = sync_q[7:4];
   assign driver_fault_status   = sync_q[11:8];
   assign remote_loopback_state = sync_q[15:12];
   assign line_attenuation_code = sync_q[35:16];

   // Live status byte zero per channel
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         stat_now[c][DF_POS]  = driver_fault_status[c];
         stat_now[c][AIS_POS] = alarm_signal_status[c];
         stat_now[c][LOS_POS] = signal_loss_status[c];
      end
   end

   // ----------------------------------------------------------------
   // Event detection
   // ----------------------------------------------------------------
   lsm_edge #(
      .W           (12)
   ) u_edge (
      .clk_in      (CLK_IN),
      .rst_in      (SYS_RST_IN),
      .status_in   (stat_now),
      .edge_sel_in (edge_sel_reg),
      .evt_out     (evt)
   );

   // Masked bits raise no event at all
   assign new_evt = evt & ~mask_reg;

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------

   // Address phase accepted only while our data phase is not busy
   assign capture = HSEL_IN && HTRANS_IN[1] && HREADY_IN &&
                    (state_reg != BUS_DATA);

   // Whole aligned words inside the channel windows only
   assign acc_ok = (HSIZE_IN == HSIZE_WORD) &&
                   (HADDR_IN[1:0] == 2'h0) &&
                   (HADDR_IN[31:10] == 22'h00_0000);

   // Next state; every transfer gets one wait cycle
   always_comb begin
      case (state_reg)
         BUS_IDLE: state_next = capture ? BUS_DATA : BUS_IDLE;
         BUS_DATA: state_next = BUS_RESP;
         BUS_RESP: state_next = capture ? BUS_DATA : BUS_IDLE;
         default:  state_next = BUS_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         state_reg <= BUS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Address phase capture
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         adr_reg   <= 8'h00;
         wr_reg    <= 1'b0;
         valid_reg <= 1'b0;
      end else if (capture) begin
         adr_reg   <= HADDR_IN[9:2];
         wr_reg    <= HWRITE_IN;
         valid_reg <= acc_ok;
      end
   end

   // Wait cycle lets write data land before any following read
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         HREADYOUT_OUT <= 1'b1;
      end else begin
         HREADYOUT_OUT <= (state_reg == BUS_DATA) || !capture;
      end
   end

   // Response is always OKAY
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         HRESP_OUT <= HRESP_OKAY;
      end else begin
         HRESP_OUT <= HRESP_OKAY;
      end
   end

   // Data phase decode
   assign dp             = (state_reg == BUS_DATA) && valid_reg;
   assign cur_ch         = adr_reg[7:6];
   assign rd_flag        = dp && !wr_reg && hit(adr_reg, FLAG_IDX);
   assign wr_flag        = dp && wr_reg && hit(adr_reg, FLAG_IDX);
   assign rd_status_zero = dp && !wr_reg &&
                           hit(adr_reg, LINE_STATUS_ZERO_IDX);
   assign rd_status_one  = dp && !wr_reg &&
                           hit(adr_reg, LINE_STATUS_ONE_IDX);
   assign wr_stat        = dp && wr_reg &&
                           (hit(adr_reg, LINE_STATUS_ZERO_IDX) ||
                            hit(adr_reg, LINE_STATUS_ONE_IDX));

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------

   // Mask bits; set means the condition raises nothing
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         mask_reg <= {NUM_CH{MASK_RST}};
      end else if (dp && wr_reg && hit(adr_reg, MASK_IDX)) begin
         mask_reg[cur_ch] <= HWDATA_IN[2:0];
      end
   end

   // Edge select bits; set means any change is an event
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         edge_sel_reg <= {NUM_CH{EDGE_RST}};
      end else if (dp && wr_reg && hit(adr_reg, EDGE_IDX)) begin
         edge_sel_reg[cur_ch] <= HWDATA_IN[2:0];
      end
   end

   // ----------------------------------------------------------------
   // Latched event flags
   // ----------------------------------------------------------------

   // Clear terms: a flag read clears all three of that channel's flags, a write clears the ones written
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         flag_clr[c] = 3'h0;
         if (cur_ch == c[1:0]) begin
            if (rd_flag) begin
               flag_clr[c] = 3'h7;
            end else if (wr_flag) begin
               flag_clr[c] = HWDATA_IN[2:0];
            end
         end
      end
   end

   // A new event wins over a clear landing in the same cycle
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         flag_reg <= {NUM_CH{FLAG_RST}};
      end else begin
         flag_reg <= (flag_reg & ~flag_clr) | new_evt;
      end
   end

   // Level interrupt while any unmasked flag stands
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= |(flag_reg & ~mask_reg);
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------

   // Status bytes read live values; writes to them change nothing
   always_comb begin
      rdata_next = 8'h00;
      if (hit(adr_reg, LINE_STATUS_ZERO_IDX)) begin
         rdata_next = {5'h00, stat_now[cur_ch]};
      end else if (hit(adr_reg, LINE_STATUS_ONE_IDX)) begin
         rdata_next = {2'h0, remote_loopback_state[cur_ch],
                       line_attenuation_code[cur_ch]};
      end else if (hit(adr_reg, FLAG_IDX)) begin
         rdata_next = {5'h00, flag_reg[cur_ch]};
      end else if (hit(adr_reg, MASK_IDX)) begin
         rdata_next = {5'h00, mask_reg[cur_ch]};
      end else if (hit(adr_reg, EDGE_IDX)) begin
         rdata_next = {5'h00, edge_sel_reg[cur_ch]};
      end
   end

   // Read data is loaded at the end of the wait cycle; unmapped is zero
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         HRDATA_OUT <= RDATA_RST;
      end else if (state_reg == BUS_DATA) begin
         HRDATA_OUT <= (valid_reg && !wr_reg) ?
                       {24'h00_0000, rdata_next} : RDATA_RST;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   sequence s_wait_then_ready;
      !HREADYOUT_OUT ##1 HREADYOUT_OUT;
   endsequence

   AST_BUS_WAIT: assert property (
      capture |=> s_wait_then_ready)
      else $error("Data phase did not take exactly one wait cycle");

   AST_STATUS_ZERO_LIVE: assert property (
      rd_status_zero |=>
         HRDATA_OUT == {29'h0000_0000, $past(stat_now[cur_ch])})
      else $error("Status byte zero read wrong live value");

   AST_STATUS_ONE_LIVE: assert property (
      rd_status_one |=> HRDATA_OUT[7:0] ==
         {2'h0, $past(remote_loopback_state[cur_ch]),
          $past(line_attenuation_code[cur_ch])})
      else $error("Status byte one read wrong value");

   AST_STAT_NO_WRITE: assert property (
      wr_stat |=> $stable(mask_reg) && $stable(edge_sel_reg))
      else $error("Write to status byte altered control state");

   AST_FLAG_SET: assert property (
      1'b1 |=> (flag_reg & $past(new_evt)) == $past(new_evt))
      else $error("Enabled event was not latched");

   AST_FLAG_CLR_READ: assert property (
      rd_flag |=> flag_reg[$past(cur_ch)] == $past(new_evt[cur_ch]))
      else $error("Flag read did not clear the latched flags");

   // Flags may rise only where the mask let the event through
   AST_MASKED_QUIET: assert property (
      ((flag_reg & ~$past(flag_reg)) & $past(mask_reg)) == '0)
      else $error("Masked condition latched a flag");

   AST_IRQ_LEVEL: assert property (
      (|(flag_reg & ~mask_reg)) ##1 (|(flag_reg & ~mask_reg))
      |-> IRQ_OUT)
      else $error("Interrupt low while unmasked flag held");

endmodule : lsm_regs

// File: line_status_monitor_regs_tb_top.sv
// Self-checking bench for the four-channel line status monitor registers
`timescale 1ns/1ps
module line_status_monitor_regs_tb_top;
   import lsm_pkg::*;

   // ----------------------------------------------------------------
   // Bench signals
   // ----------------------------------------------------------------
   logic        clk;
   logic        rst;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [3:0]  drv;
   logic [3:0]  alarm;
   logic [3:0]  loss;
   logic [3:0]  rloop;
   logic [19:0] atten;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        irq;
   int          error_cnt;
   int          num_checks;

   // ----------------------------------------------------------------
   // Device under test; ready loops back as the bus hready
   // ----------------------------------------------------------------
   lsm_regs u_lsm_regs (
      .CLK_IN        (clk),
      .SYS_RST_IN    (rst),
      .HSEL_IN       (1'b1),
      .HADDR_IN      (haddr),
      .HTRANS_IN     (htrans),
      .HWRITE_IN     (hwrite),
      .HSIZE_IN      (HSIZE_WORD),
      .HWDATA_IN     (hwdata),
      .HREADY_IN     (hready),
      .DRV_FAULT_IN  (drv),
      .ALARM_SIG_IN  (alarm),
      .SIG_LOSS_IN   (loss),
      .REM_LOOP_IN   (rloop),
      .LINE_ATTEN_IN (atten),
      .HRDATA_OUT    (hrdata),
      .HREADYOUT_OUT (hready),
      .HRESP_OUT     (hresp),
      .IRQ_OUT       (irq)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   // Verdict and end of run, also reached by the watchdog
   task automatic results();
      if (error_cnt == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Waits for ready under a bound; the slave never answers wrong
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (n >= 20)
         chk(32'h0000_0000, 32'h0000_0001);
   endtask : wait_ready

   // One single word transfer; byte address is four times the index
   task automatic xfer(input logic wr, input logic [7:0] idx, input int ch,
                       input logic [31:0] wd, output logic [31:0] rd);
      logic [7:0] full;
      full = idx + 8'(ch * 64);
      @(posedge clk);
      haddr  <= {22'h00_0000, full, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
      chk({31'h0000_0000, hresp}, {31'h0000_0000, HRESP_OKAY});
   endtask : xfer

   task automatic wr(input logic [7:0] idx, input int ch,
                     input logic [31:0] d);
      logic [31:0] unused;
      xfer(1'b1, idx, ch, d, unused);
   endtask : wr

   task automatic rdchk(input logic [7:0] idx, input int ch,
                        input logic [31:0] exp);
      logic [31:0] d;
      xfer(1'b0, idx, ch, 32'h0000_0000, d);
      chk(d, exp);
   endtask : rdchk

   // Status pins go through a synchroniser; give it time to land
   task automatic settle();
      repeat (10) @(posedge clk);
   endtask : settle

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_reset();
      for (int c = 0; c < 4; c++) begin
         rdchk(LINE_STATUS_ZERO_IDX, c, 32'h0000_0000);
         rdchk(LINE_STATUS_ONE_IDX, c, 32'h0000_0000);
      end
      rdchk(MASK_IDX, 0, 32'h0000_0007);
      chk({31'h0000_0000, irq}, 32'h0000_0000);
   endtask : test_reset

   // Two pin patterns, opposite except on two attenuation codes; every channel read back live
   task automatic test_status();
      logic [31:0] e0;
      logic [31:0] e1;
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         drv   <= p ? 4'b1010 : 4'b0101;
         alarm <= p ? 4'b1100 : 4'b0011;
         loss  <= p ? 4'b0110 : 4'b1001;
         rloop <= p ? 4'b0011 : 4'b1100;
         atten <= p ? {5'h00, 5'h01, 5'h0A, 5'h16}
                    : {5'h1F, 5'h16, 5'h15, 5'h00};
         settle();
         for (int c = 0; c < 4; c++) begin
            e0 = {29'h0, drv[c], alarm[c], loss[c]};
            e1 = {26'h0, rloop[c], atten[5*c +: 5]};
            rdchk(LINE_STATUS_ZERO_IDX, c, e0);
            rdchk(LINE_STATUS_ONE_IDX, c, e1);
         end
      end
      wr(LINE_STATUS_ZERO_IDX, 2, 32'h0000_00FF);
      wr(LINE_STATUS_ONE_IDX, 2, 32'h0000_00FF);
      e0 = {29'h0, drv[2], alarm[2], loss[2]};
      e1 = {26'h0, rloop[2], atten[14:10]};
      rdchk(LINE_STATUS_ZERO_IDX, 2, e0);
      rdchk(LINE_STATUS_ONE_IDX, 2, e1);
   endtask : test_status

   task automatic set_pin(input int b, input logic v);
      @(posedge clk);
      case (b)
         0: loss[1]  <= v;
         1: alarm[1] <= v;
         default: drv[1] <= v;
      endcase
   endtask : set_pin

   // Rise and any-change selection, clear by read and write, masking
   task automatic test_events();
      logic [31:0] bit_v;
      for (int b = 0; b < 3; b++) begin
         bit_v = 32'h0000_0001 << b;
         wr(FLAG_IDX, 1, 32'h0000_0007);
         wr(MASK_IDX, 1, ~bit_v & 32'h0000_0007);
         rdchk(MASK_IDX, 1, ~bit_v & 32'h0000_0007);
         wr(EDGE_IDX, 1, 32'h0000_0000);
         set_pin(b, 1'b1);
         settle();
         chk({31'h0, irq}, 32'h0000_0001);
         rdchk(FLAG_IDX, 1, bit_v);
         rdchk(FLAG_IDX, 1, 32'h0000_0000);
         chk({31'h0, irq}, 32'h0000_0000);
         set_pin(b, 1'b0);
         settle();
         rdchk(FLAG_IDX, 1, 32'h0000_0000);
         wr(EDGE_IDX, 1, bit_v);
         rdchk(EDGE_IDX, 1, bit_v);
         set_pin(b, 1'b1);
         settle();
         wr(FLAG_IDX, 1, bit_v);
         rdchk(FLAG_IDX, 1, 32'h0000_0000);
         set_pin(b, 1'b0);
         settle();
         chk({31'h0, irq}, 32'h0000_0001);
         rdchk(FLAG_IDX, 1, bit_v);
         wr(MASK_IDX, 1, 32'h0000_0007);
         set_pin(b, 1'b1);
         settle();
         rdchk(FLAG_IDX, 1, 32'h0000_0000);
         chk({31'h0, irq}, 32'h0000_0000);
         set_pin(b, 1'b0);
      end
   endtask : test_events

   // Unmapped index reads zero and swallows writes
   task automatic test_unmapped();
      wr(8'h13, 0, 32'h0000_00FF);
      rdchk(8'h13, 0, 32'h0000_0000);
      rdchk(8'h3F, 3, 32'h0000_0000);
   endtask : test_unmapped

   // ----------------------------------------------------------------
   // Clock, reset, main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      error_cnt  = 0;
      num_checks = 0;
      rst    = 1'b1;
      haddr  = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      drv    = 4'h0;
      alarm  = 4'h0;
      loss   = 4'h0;
      rloop  = 4'h0;
      atten  = 20'h0_0000;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      test_reset();
      test_status();
      @(posedge clk);
      drv   <= 4'h0;
      alarm <= 4'h0;
      loss  <= 4'h0;
      settle();
      test_events();
      test_unmapped();
      results();
   end

   // Whole run needs about five hundred cycles; this is far beyond that
   initial begin
      #100_000;
      error_cnt++;
      results();
   end

endmodule : line_status_monitor_regs_tb_top
